// >>> pkg/hdi_pkg.sv
package hdi_pkg;
    // bus target address and direction bit
    localparam logic [6:0] HDI_TARGET_ADDR = 7'h66;
    localparam logic HDI_DIR_READ = 1'b1;
    localparam logic HDI_DIR_WRITE = 1'b0;
    localparam logic [3:0] HDI_BYTE_BITS = 4'h8;
    // register file
    localparam int HDI_NUM_REGS = 6;
    localparam logic [7:0] HDI_IDX_HAPTIC_A = 8'h02;
    localparam logic [7:0] HDI_IDX_HAPTIC_B = 8'h03;
    localparam int HDI_FWD_LSB = 0;
    localparam int HDI_REV_LSB = 0;
    localparam logic [5:0][7:0] HDI_REG_RESET = {8'h1a, 8'h00, 8'h85, 8'h0a, 8'h00, 8'h01};
    // timing
    localparam int HDI_CLK_PERIOD_PS = 5000;
    localparam int HDI_MAX_RATE_KBPS = 400;
    localparam int HDI_BIT_PERIOD_PS = 1000000000 / HDI_MAX_RATE_KBPS;
    localparam int HDI_QTR_CYCLES = (HDI_BIT_PERIOD_PS / 4 + HDI_CLK_PERIOD_PS - 1) / HDI_CLK_PERIOD_PS;
    localparam int HDI_RESP_LATENCY_US = 40;
    localparam int HDI_RESP_CYCLES = HDI_RESP_LATENCY_US * 1000000 / HDI_CLK_PERIOD_PS;
    localparam int HDI_PHASE_UNIT = 2;
endpackage : hdi_pkg

// >>> pkg/hdi_i2c_if.sv
`timescale 1ns/100ps
`default_nettype none
interface hdi_i2c_if;
    logic m_scl_out;
    logic m_scl_oe;
    logic m_sda_out;
    logic m_sda_oe;
    logic t_sda_out;
    logic t_sda_oe;
    logic scl;
    logic sda;
    // pulled-up open-drain wires: any enabled low driver wins
    assign scl = ~(m_scl_oe & ~m_scl_out);
    assign sda = ~(m_sda_oe & ~m_sda_out) & ~(t_sda_oe & ~t_sda_out);
    modport master(output m_scl_out, m_scl_oe, m_sda_out, m_sda_oe, input scl, sda);
    modport target(output t_sda_out, t_sda_oe, input scl, sda);
endinterface : hdi_i2c_if
`default_nettype wire

// >>> src/hdi_host.sv
`timescale 1ns/100ps
`default_nettype none
module hdi_host
    import hdi_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // bus
    hdi_i2c_if.master bus,
    // command port
    input wire logic cmd_valid_in,
    input wire logic cmd_read_in,
    input wire logic [7:0] cmd_index_in,
    input wire logic [7:0] cmd_data_in,
    output logic cmd_ready_out,
    output logic done_out,
    output logic nack_out,
    output logic [7:0] rdata_out
);
    typedef enum logic [7:0] {
        H_IDLE = 8'h01, H_START = 8'h02, H_TXB = 8'h04, H_RXACK = 8'h08,
        H_RSTART = 8'h10, H_RXB = 8'h20, H_TXNACK = 8'h40, H_STOP = 8'h80
    } hdi_hstate_type;

    hdi_hstate_type state_reg, state_next;
    logic [1:0] phase_reg, phase_next, stage_reg, stage_next;
    logic [7:0] qcnt_reg, qcnt_next, shift_reg, shift_next, rdata_reg, rdata_next;
    logic [7:0] idx_reg, idx_next, data_reg, data_next;
    logic [3:0] bit_reg, bit_next;
    logic rd_reg, rd_next, ack_reg, ack_next, nack_reg, nack_next;
    logic done_reg, done_next, ready_reg, ready_next;
    logic scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next, low_reg;
    logic scl_s1, scl_s2, sda_s1, sda_s2;
    logic tick;
    logic [1:0] lines;

    // line levels {scl, sda} for a state and quarter phase
    function automatic logic [1:0] host_lines(input hdi_hstate_type s, input logic [1:0] p,
                                              input logic b);
        logic hi;
        hi = (p == 2'd1) || (p == 2'd2);
        case (s)
            H_START: host_lines = {p != 2'd3, p == 2'd0};
            H_RSTART: host_lines = {hi, p < 2'd2};
            H_STOP: host_lines = {p != 2'd0, p >= 2'd2};
            H_TXB: host_lines = {hi, b};
            H_RXACK, H_RXB, H_TXNACK: host_lines = {hi, 1'b1};
            default: host_lines = 2'b11;
        endcase
    endfunction : host_lines

    // wait out a held-low clock before counting the high quarter
    assign tick = (qcnt_reg == 8'(HDI_QTR_CYCLES - 1)) && !(phase_reg == 2'd1 && !scl_s2);

    always_comb begin
        state_next = state_reg;
        phase_next = phase_reg;
        stage_next = stage_reg;
        qcnt_next = qcnt_reg;
        shift_next = shift_reg;
        rdata_next = rdata_reg;
        idx_next = idx_reg;
        data_next = data_reg;
        bit_next = bit_reg;
        rd_next = rd_reg;
        ack_next = ack_reg;
        nack_next = nack_reg;
        done_next = 1'b0;
        ready_next = ready_reg;
        if (state_reg == H_IDLE) begin
            qcnt_next = 8'h00;
            if (cmd_valid_in) begin
                state_next = H_START;
                phase_next = 2'd0;
                idx_next = cmd_index_in;
                data_next = cmd_data_in;
                rd_next = cmd_read_in;
                ready_next = 1'b0;
            end
        end else if (!tick) begin
            if (!(phase_reg == 2'd1 && !scl_s2)) begin
                qcnt_next = qcnt_reg + 8'h01;
            end
        end else begin
            qcnt_next = 8'h00;
            phase_next = phase_reg + 2'd1;
            if (phase_reg == 2'd2 && state_reg == H_RXB) begin
                shift_next = {shift_reg[6:0], sda_s2};
            end
            if (phase_reg == 2'd2 && state_reg == H_RXACK) begin
                ack_next = ~sda_s2;
            end
            if (phase_reg == 2'd3) begin
                case (state_reg)
                    H_START: begin
                        state_next = H_TXB;
                        shift_next = {HDI_TARGET_ADDR, HDI_DIR_WRITE};
                        bit_next = 4'h0;
                        stage_next = 2'd0;
                    end
                    H_RSTART: begin
                        state_next = H_TXB;
                        shift_next = {HDI_TARGET_ADDR, HDI_DIR_READ};
                        bit_next = 4'h0;
                        stage_next = 2'd3;
                    end
                    H_TXB, H_RXB: begin
                        if (state_reg == H_TXB) begin
                            shift_next = {shift_reg[6:0], 1'b0};
                        end
                        bit_next = bit_reg + 4'h1;
                        if (bit_reg == HDI_BYTE_BITS - 4'h1) begin
                            state_next = (state_reg == H_TXB) ? H_RXACK : H_TXNACK;
                            rdata_next = (state_reg == H_RXB) ? shift_reg : rdata_reg;
                        end
                    end
                    H_RXACK: begin
                        bit_next = 4'h0;
                        if (!ack_reg) begin
                            state_next = H_STOP;
                        end else begin
                            case (stage_reg)
                                2'd0: begin
                                    state_next = H_TXB;
                                    shift_next = idx_reg;
                                    stage_next = 2'd1;
                                end
                                2'd1: begin
                                    state_next = rd_reg ? H_RSTART : H_TXB;
                                    shift_next = data_reg;
                                    stage_next = 2'd2;
                                end
                                2'd2: state_next = H_STOP;
                                default: state_next = H_RXB;
                            endcase
                        end
                    end
                    H_TXNACK: state_next = H_STOP;
                    default: begin
                        state_next = H_IDLE;
                        nack_next = ~ack_reg;
                        done_next = 1'b1;
                        ready_next = 1'b1;
                    end
                endcase
            end
        end
        lines = host_lines(state_next, phase_next, shift_next[7]);
        scl_oe_next = ~lines[1];
        sda_oe_next = ~lines[0];
    end

    always_ff @(posedge ref_clk_in) begin
        scl_s1 <= bus.scl;
        scl_s2 <= scl_s1;
        sda_s1 <= bus.sda;
        sda_s2 <= sda_s1;
        if (srst_in) begin
            state_reg <= H_IDLE;
            phase_reg <= 2'd0;
            stage_reg <= 2'd0;
            qcnt_reg <= 8'h00;
            shift_reg <= 8'h00;
            rdata_reg <= 8'h00;
            idx_reg <= 8'h00;
            data_reg <= 8'h00;
            bit_reg <= 4'h0;
            rd_reg <= 1'b0;
            ack_reg <= 1'b0;
            nack_reg <= 1'b0;
            done_reg <= 1'b0;
            ready_reg <= 1'b1;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            low_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            stage_reg <= stage_next;
            qcnt_reg <= qcnt_next;
            shift_reg <= shift_next;
            rdata_reg <= rdata_next;
            idx_reg <= idx_next;
            data_reg <= data_next;
            bit_reg <= bit_next;
            rd_reg <= rd_next;
            ack_reg <= ack_next;
            nack_reg <= nack_next;
            done_reg <= done_next;
            ready_reg <= ready_next;
            scl_oe_reg <= scl_oe_next;
            sda_oe_reg <= sda_oe_next;
            low_reg <= 1'b0;
        end
    end

    assign bus.m_scl_oe = scl_oe_reg;
    assign bus.m_sda_oe = sda_oe_reg;
    assign bus.m_scl_out = low_reg;
    assign bus.m_sda_out = low_reg;
    assign cmd_ready_out = ready_reg;
    assign done_out = done_reg;
    assign nack_out = nack_reg;
    assign rdata_out = rdata_reg;
endmodule : hdi_host
`default_nettype wire

// >>> src/hdi_target.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - answer only target address 1100110
// - work at any rate to 400 kbit/s
// - both lines released high when idle
// - master starts transfers; target acknowledges bytes
// - read: index write, repeated start, read address
// - pull data low after address, index, data
// - master not-acknowledges read byte, then stops
// - direction bit: one reads, zero writes
// - address sent most significant bit first
// - full index byte selects the register
// - exactly one data byte per transfer
// - six registers all readable and writable
// - enable drives forward; trigger edge forward-reverse
// - motor responds about 40 us later
module hdi_target
    import hdi_pkg::*;
#(
    parameter int RESP_CYCLES = HDI_RESP_CYCLES,
    parameter int PHASE_UNIT = HDI_PHASE_UNIT
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // bus
    hdi_i2c_if.target bus,
    // motor control pins
    input wire logic haptic_trigger_in,
    input wire logic vibrator_enable_in,
    output logic motor_fwd_out,
    output logic motor_rev_out,
    // register contents
    output logic [5:0][7:0] regs_out
);
    typedef enum logic [8:0] {
        T_IDLE = 9'h001, T_ADDR = 9'h002, T_ADDR_ACK = 9'h004, T_INDEX = 9'h008,
        T_INDEX_ACK = 9'h010, T_WDATA = 9'h020, T_WDATA_ACK = 9'h040,
        T_RDATA = 9'h080, T_RDATA_ACK = 9'h100
    } hdi_tstate_type;

    typedef enum logic [4:0] {
        M_IDLE = 5'h01, M_WAIT = 5'h02, M_FWD = 5'h04, M_REV = 5'h08, M_VIB = 5'h10
    } hdi_mstate_type;

    hdi_tstate_type state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg, shift_next, ptr_reg, ptr_next, rd_byte;
    logic [7:0] wr_idx_reg, wr_idx_next, wr_data_reg, wr_data_next;
    logic wr_pend_reg, wr_pend_next, rw_reg, rw_next, sda_oe_reg, sda_oe_next;
    logic [5:0][7:0] regs_reg, regs_next;
    logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
    logic trg_s1, trg_s2, trg_s3, vib_s1, vib_s2;
    logic scl_rise, scl_fall, start_det, stop_det, trg_rise, low_reg;

    hdi_mstate_type mst_reg, mst_next;
    logic [31:0] mcnt_reg, mcnt_next, fwd_len, rev_len;
    logic haptic_reg, haptic_next, fwd_reg, fwd_next, rev_reg, rev_next;

    // reads and writes share this decode so unmapped indices stay inert
    function automatic logic idx_valid(input logic [7:0] idx);
        idx_valid = idx < 8'(HDI_NUM_REGS);
    endfunction : idx_valid

    function automatic logic [7:0] read_reg(input logic [5:0][7:0] r, input logic [7:0] idx);
        read_reg = idx_valid(idx) ? r[idx[2:0]] : 8'h00;
    endfunction : read_reg

    // edges from the second sync stage onward only
    assign scl_rise = scl_s2 & ~scl_s3;
    assign scl_fall = ~scl_s2 & scl_s3;
    assign start_det = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
    assign stop_det = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;
    assign trg_rise = trg_s2 & ~trg_s3;
    assign rd_byte = read_reg(regs_reg, ptr_reg);

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        ptr_next = ptr_reg;
        wr_idx_next = wr_idx_reg;
        wr_data_next = wr_data_reg;
        wr_pend_next = wr_pend_reg;
        rw_next = rw_reg;
        sda_oe_next = sda_oe_reg;
        regs_next = regs_reg;
        if (stop_det) begin
            state_next = T_IDLE;
            sda_oe_next = 1'b0;
            wr_pend_next = 1'b0;
            if (wr_pend_reg && idx_valid(wr_idx_reg)) begin
                regs_next[wr_idx_reg[2:0]] = wr_data_reg;
            end
        end else if (start_det) begin
            state_next = T_ADDR;
            cnt_next = 4'h0;
            sda_oe_next = 1'b0;
        end else begin
            case (state_reg)
                T_ADDR, T_INDEX, T_WDATA: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_s2};
                        cnt_next = cnt_reg + 4'h1;
                    end
                    if (scl_fall && cnt_reg == HDI_BYTE_BITS) begin
                        cnt_next = 4'h0;
                        sda_oe_next = 1'b1;
                        case (state_reg)
                            T_ADDR: begin
                                rw_next = shift_reg[0];
                                if (shift_reg[7:1] == HDI_TARGET_ADDR) begin
                                    state_next = T_ADDR_ACK;
                                end else begin
                                    state_next = T_IDLE;
                                    sda_oe_next = 1'b0;
                                end
                            end
                            T_INDEX: begin
                                ptr_next = shift_reg;
                                state_next = T_INDEX_ACK;
                            end
                            default: begin
                                wr_idx_next = ptr_reg;
                                wr_data_next = shift_reg;
                                wr_pend_next = 1'b1;
                                state_next = T_WDATA_ACK;
                            end
                        endcase
                    end
                end
                T_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw_reg == HDI_DIR_READ) begin
                            shift_next = rd_byte << 1;
                            sda_oe_next = ~rd_byte[7];
                            cnt_next = 4'h1;
                            state_next = T_RDATA;
                        end else begin
                            sda_oe_next = 1'b0;
                            state_next = T_INDEX;
                        end
                    end
                end
                T_INDEX_ACK: begin
                    if (scl_fall) begin
                        sda_oe_next = 1'b0;
                        state_next = T_WDATA;
                    end
                end
                T_WDATA_ACK: begin
                    if (scl_fall) begin
                        sda_oe_next = 1'b0;
                        state_next = T_IDLE;
                    end
                end
                T_RDATA: begin
                    if (scl_fall) begin
                        if (cnt_reg == HDI_BYTE_BITS) begin
                            sda_oe_next = 1'b0;
                            state_next = T_RDATA_ACK;
                        end else begin
                            sda_oe_next = ~shift_reg[7];
                            shift_next = {shift_reg[6:0], 1'b0};
                            cnt_next = cnt_reg + 4'h1;
                        end
                    end
                end
                T_RDATA_ACK: begin
                    // one byte per read whatever the master answers
                    if (scl_rise) begin
                        state_next = T_IDLE;
                    end
                end
                default: state_next = T_IDLE;
            endcase
        end
    end

    assign fwd_len = 32'(regs_reg[HDI_IDX_HAPTIC_A[2:0]][HDI_FWD_LSB +: 4]) * 32'(PHASE_UNIT);
    assign rev_len = 32'(regs_reg[HDI_IDX_HAPTIC_B[2:0]][HDI_REV_LSB +: 4]) * 32'(PHASE_UNIT);

    always_comb begin
        mst_next = mst_reg;
        mcnt_next = mcnt_reg + 32'h1;
        haptic_next = haptic_reg;
        case (mst_reg)
            M_IDLE: begin
                mcnt_next = 32'h0;
                if (trg_rise || vib_s2) begin
                    haptic_next = trg_rise;
                    mst_next = M_WAIT;
                end
            end
            M_WAIT: begin
                if (!haptic_reg && !vib_s2) begin
                    mst_next = M_IDLE;
                end else if (mcnt_reg >= 32'(RESP_CYCLES - 1)) begin
                    mcnt_next = 32'h0;
                    mst_next = haptic_reg ? M_FWD : M_VIB;
                end
            end
            M_FWD: begin
                if (mcnt_reg + 32'h1 >= fwd_len) begin
                    mcnt_next = 32'h0;
                    mst_next = M_REV;
                end
            end
            M_REV: begin
                if (mcnt_reg + 32'h1 >= rev_len) begin
                    mst_next = M_IDLE;
                end
            end
            M_VIB: begin
                mcnt_next = 32'h0;
                if (!vib_s2) begin
                    mst_next = M_IDLE;
                end
            end
            default: mst_next = M_IDLE;
        endcase
        fwd_next = (mst_next == M_FWD) || (mst_next == M_VIB);
        rev_next = (mst_next == M_REV);
    end

    always_ff @(posedge ref_clk_in) begin
        scl_s1 <= bus.scl;
        scl_s2 <= scl_s1;
        scl_s3 <= scl_s2;
        sda_s1 <= bus.sda;
        sda_s2 <= sda_s1;
        sda_s3 <= sda_s2;
        trg_s1 <= haptic_trigger_in;
        trg_s2 <= trg_s1;
        trg_s3 <= trg_s2;
        vib_s1 <= vibrator_enable_in;
        vib_s2 <= vib_s1;
        if (srst_in) begin
            state_reg <= T_IDLE;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            wr_idx_reg <= 8'h00;
            wr_data_reg <= 8'h00;
            wr_pend_reg <= 1'b0;
            rw_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            regs_reg <= HDI_REG_RESET;
            low_reg <= 1'b0;
            mst_reg <= M_IDLE;
            mcnt_reg <= 32'h0;
            haptic_reg <= 1'b0;
            fwd_reg <= 1'b0;
            rev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            ptr_reg <= ptr_next;
            wr_idx_reg <= wr_idx_next;
            wr_data_reg <= wr_data_next;
            wr_pend_reg <= wr_pend_next;
            rw_reg <= rw_next;
            sda_oe_reg <= sda_oe_next;
            regs_reg <= regs_next;
            low_reg <= 1'b0;
            mst_reg <= mst_next;
            mcnt_reg <= mcnt_next;
            haptic_reg <= haptic_next;
            fwd_reg <= fwd_next;
            rev_reg <= rev_next;
        end
    end

    assign bus.t_sda_oe = sda_oe_reg;
    assign bus.t_sda_out = low_reg;
    assign motor_fwd_out = fwd_reg;
    assign motor_rev_out = rev_reg;
    assign regs_out = regs_reg;
endmodule : hdi_target
`default_nettype wire

// >>> dv/hdi_i2c_sva.sv
`timescale 1ns/100ps
`default_nettype none
module hdi_i2c_sva (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // link wires
    input wire logic m_scl_out,
    input wire logic m_scl_oe,
    input wire logic m_sda_out,
    input wire logic m_sda_oe,
    input wire logic t_sda_out,
    input wire logic t_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    property p_tgt_od; t_sda_oe |-> !t_sda_out; endproperty
    a_tgt_od: assert property (p_tgt_od) else $error("target drove sda high");
    property p_host_od; m_scl_oe || m_sda_oe |-> !m_scl_out && !m_sda_out; endproperty
    a_host_od: assert property (p_host_od) else $error("host drove a line high");
    property p_rst_rel; $fell(srst_in) |-> !m_scl_oe && !m_sda_oe && !t_sda_oe; endproperty
    a_rst_rel: assert property (p_rst_rel) else $error("line pulled after reset");
    // target may move sda only while scl is low, else it fakes a start or stop
    property p_tgt_edge; scl && $past(scl) |-> $stable(t_sda_oe); endproperty
    a_tgt_edge: assert property (p_tgt_edge) else $error("target moved sda, scl high");
    property p_scl_high; $rose(scl) |-> scl [*8]; endproperty
    a_scl_high: assert property (p_scl_high) else $error("scl high too short");
    property p_scl_low; $fell(scl) |-> !scl [*8]; endproperty
    a_scl_low: assert property (p_scl_low) else $error("scl low too short");
    property p_stop_idle; scl && $rose(sda) |-> (scl && sda) [*8]; endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("lines not idle after stop");
    property p_start; scl && $fell(sda) |-> scl [*8] ##[1:300] !scl; endproperty
    a_start: assert property (p_start) else $error("no clocking after start");
    c_start: cover property (scl && $fell(sda));
    c_ack: cover property ($rose(t_sda_oe));
    c_stop: cover property (scl && $rose(sda));
endmodule : hdi_i2c_sva
`default_nettype wire

// >>> dv/haptic_driver_i2c_register_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
module haptic_driver_i2c_register_port_tb;
    import hdi_pkg::*;
    // short response delay keeps the run brief
    localparam int RESP = 20;
    logic ref_clk = 0, srst = 1, cmd_valid = 0, cmd_read = 0, trig = 0, vib = 0;
    logic cmd_ready, done, nack, fwd, rev, s, pscl = 1, psda = 1;
    logic [7:0] cmd_index = 8'h00, cmd_data = 8'h00, rdata, sh = 8'h00, d, wa;
    logic [3:0] a, b;
    logic [5:0][7:0] regs, exp_regs = HDI_REG_RESET;
    logic [7:0] caps[$];
    int nb = 8, miscompares = 0, samples_checked = 0;
    hdi_i2c_if bus_if();
    hdi_i2c_if bus2_if();
    hdi_host hdi_host_i (.ref_clk_in(ref_clk), .srst_in(srst), .bus(bus_if),
        .cmd_valid_in(cmd_valid), .cmd_read_in(cmd_read), .cmd_index_in(cmd_index),
        .cmd_data_in(cmd_data), .cmd_ready_out(cmd_ready), .done_out(done),
        .nack_out(nack), .rdata_out(rdata));
    hdi_target #(.RESP_CYCLES(RESP), .PHASE_UNIT(HDI_PHASE_UNIT)) hdi_target_i (
        .ref_clk_in(ref_clk), .srst_in(srst), .bus(bus_if), .haptic_trigger_in(trig),
        .vibrator_enable_in(vib), .motor_fwd_out(fwd), .motor_rev_out(rev), .regs_out(regs));
    // second target faces a bench master that sends a foreign address
    hdi_target #(.RESP_CYCLES(RESP), .PHASE_UNIT(HDI_PHASE_UNIT)) hdi_target_i2 (
        .ref_clk_in(ref_clk), .srst_in(srst), .bus(bus2_if), .haptic_trigger_in(1'b0),
        .vibrator_enable_in(1'b0), .motor_fwd_out(), .motor_rev_out(), .regs_out());
    hdi_i2c_sva hdi_i2c_sva_i (.ref_clk_in(ref_clk), .srst_in(srst),
        .m_scl_out(bus_if.m_scl_out), .m_scl_oe(bus_if.m_scl_oe),
        .m_sda_out(bus_if.m_sda_out), .m_sda_oe(bus_if.m_sda_oe),
        .t_sda_out(bus_if.t_sda_out), .t_sda_oe(bus_if.t_sda_oe),
        .scl(bus_if.scl), .sda(bus_if.sda));
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    // wire monitor: first byte after every start condition
    always @(posedge ref_clk) begin
        pscl <= bus_if.scl;
        psda <= bus_if.sda;
        if (pscl && bus_if.scl && psda && !bus_if.sda) begin
            nb <= 0;
        end else if (!pscl && bus_if.scl && nb < 8) begin
            sh <= {sh[6:0], bus_if.sda};
            nb <= nb + 1;
            if (nb == 7) caps.push_back({sh[6:0], bus_if.sda});
        end
    end
    function automatic logic [7:0] exp_rd(input logic [7:0] idx);
        return (idx < HDI_NUM_REGS) ? exp_regs[idx[2:0]] : 8'h00;
    endfunction : exp_rd
    task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic xfer(input logic rd, input logic [7:0] idx, input logic [7:0] dv);
        int n;
        caps.delete();
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_read <= rd;
        cmd_index <= idx;
        cmd_data <= dv;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        for (n = 0; n < 40000 && done !== 1'b1; n++) @(negedge ref_clk);
        chk("done", 48'h1, 48'(done));
        if (!rd && idx < HDI_NUM_REGS) exp_regs[idx[2:0]] = dv;
        chk("nack", 48'h0, 48'(nack));
        chk("starts", 48'(rd ? 2 : 1), 48'(caps.size()));
        chk("addr_w", 48'({HDI_TARGET_ADDR, HDI_DIR_WRITE}), 48'(caps[0]));
        if (rd) chk("addr_r", 48'({HDI_TARGET_ADDR, HDI_DIR_READ}), 48'(caps[1]));
        if (rd) chk("rdata", 48'(exp_rd(idx)), 48'(rdata));
        chk("idle", 48'h7, 48'({cmd_ready, bus_if.scl, bus_if.sda}));
        repeat (8) @(negedge ref_clk);
        chk("regs", exp_regs, regs);
        $display("test xfer rd=%0d idx=%h done", rd, idx);
    endtask : xfer
    task automatic bbit(input logic v, output logic sv);
        bus2_if.m_scl_oe <= 1'b1;
        repeat (125) @(posedge ref_clk);
        bus2_if.m_sda_oe <= ~v;
        repeat (125) @(posedge ref_clk);
        bus2_if.m_scl_oe <= 1'b0;
        repeat (125) @(posedge ref_clk);
        sv = bus2_if.sda;
        repeat (125) @(posedge ref_clk);
    endtask : bbit
    task automatic haptic();
        int t, f, r;
        t = 0;
        f = 0;
        r = 0;
        @(posedge ref_clk);
        trig <= 1'b1;
        @(negedge ref_clk);
        while (fwd !== 1'b1 && t < 200) begin
            t++;
            @(negedge ref_clk);
        end
        while (fwd === 1'b1 && f < 200) begin
            f++;
            @(negedge ref_clk);
        end
        while (rev === 1'b1 && r < 200) begin
            r++;
            @(negedge ref_clk);
        end
        @(posedge ref_clk);
        trig <= 1'b0;
        chk("delay", 48'h1, 48'(t >= RESP && t <= RESP + 8));
        chk("fwd", 48'(a * HDI_PHASE_UNIT), 48'(f));
        chk("rev", 48'(b * HDI_PHASE_UNIT), 48'(r));
        $display("test haptic done");
    endtask : haptic
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (95000) @(posedge ref_clk);
        miscompares++;
        conclude();
    end
    initial begin
        bus2_if.m_scl_out = 1'b0;
        bus2_if.m_sda_out = 1'b0;
        bus2_if.m_scl_oe = 1'b0;
        bus2_if.m_sda_oe = 1'b0;
        void'($urandom(32'h32009e37));
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        @(negedge ref_clk);
        chk("reset_regs", HDI_REG_RESET, regs);
        d = 8'($urandom);
        a = 4'(1 + $urandom % 15);
        b = 4'(1 + $urandom % 15);
        xfer(1'b0, HDI_IDX_HAPTIC_A, {d[7:4], a});
        xfer(1'b0, HDI_IDX_HAPTIC_B, {d[3:0], b});
        xfer(1'b1, HDI_IDX_HAPTIC_B, 8'h00);
        haptic();
        vib <= 1'b1;
        repeat (RESP + 10) @(negedge ref_clk);
        chk("vib", 48'h2, 48'({fwd, rev}));
        @(posedge ref_clk);
        vib <= 1'b0;
        repeat (8) @(negedge ref_clk);
        chk("vib_off", 48'h0, 48'({fwd, rev}));
        $display("test vibrator done");
        xfer(1'b0, 8'(HDI_NUM_REGS + $urandom % 250), d);
        xfer(1'b1, 8'hff, 8'h00);
        wa = {HDI_TARGET_ADDR ^ 7'(1 + $urandom % 127), HDI_DIR_WRITE};
        @(posedge ref_clk);
        bus2_if.m_sda_oe <= 1'b1;
        repeat (125) @(posedge ref_clk);
        for (int i = 7; i >= 0; i--) bbit(wa[i], s);
        bbit(1'b1, s);
        chk("foreign_ack", 48'h1, 48'(s));
        bbit(1'b0, s);
        bus2_if.m_sda_oe <= 1'b0;
        repeat (125) @(posedge ref_clk);
        $display("test foreign address done");
        conclude();
    end
endmodule : haptic_driver_i2c_register_port_tb
`default_nettype wire
